/* File: hdl/ocrf_filter.sv */
// The address-and-strobe port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
// Notes on behaviour
// - request bit 0 selects demand data and page-table reads only
// - request bit 1 selects demand and first-level prefetch ownership reads
// - request bit 2 selects demand and first-level instruction reads
// - request bit 3 selects modified-to-exclusive writebacks
// - bits 4 to 6 select L2 prefetch data, ownership, code reads
// - bits 7 to 9 select L2 prefetches into L3: load, ownership, code
// - bit 10 selects locked requests, bit 11 streaming stores
// - bit 15 selects any other interface request, including I/O
// - without a request bit and valid response pattern the count holds its value
// - several set bits count any transaction in any selected class
// - response valid when catch-all, or supplier and snoop bits set
// - catch-all bit 16 accepts any response
// - bits 18 to 21 select L3 states M E S F, bit 22 local DRAM
// - bit 17 selects responses without supplier information
// - bit 31 no snoop detail, bit 32 no snoop needed
// - bit 33 selects snoops that missed every cache
// - bit 34 selects snoop hits without forwarding
// - bit 35 selects clean forwards from a remote socket
// - bit 36 selects snoops finding a modified line
// - bit 37 selects non-DRAM targets such as memory-mapped I/O
// - each of two event codes uses its own configuration register
module ocrf_filter #(
    parameter int CNT_W = 32
) (
    input wire logic i_clock,
    input wire logic i_sys_rst,
    input wire logic [3:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    input wire logic i_done,
    input wire logic [3:0] i_req,
    input wire logic [3:0] i_sup,
    input wire logic [2:0] i_snp,
    output logic [CNT_W-1:0] o_count0,
    output logic [CNT_W-1:0] o_count1
);
    initial begin
        if (CNT_W < 1 || CNT_W > 32) begin
            $error("CNT_W must be 1 to 32");
        end
    end

    // =========================================
    // state
    typedef struct packed {
        logic [37:0] cfg0;
        logic [37:0] cfg1;
        logic [CNT_W-1:0] cnt0;
        logic [CNT_W-1:0] cnt1;
        logic [31:0] rdata;
    } ocrf_state_t;

    ocrf_state_t st_q;
    ocrf_state_t st_d;
    logic hit0;
    logic hit1;
    logic valid0;
    logic valid1;

    // =========================================
    // per-event filters, each fed by its own register
    ocrf_match u_match0 (
        .i_cfg(st_q.cfg0),
        .i_req(i_req),
        .i_sup(i_sup),
        .i_snp(i_snp),
        .o_hit(hit0),
        .o_cfg_valid(valid0)
    );
    ocrf_match u_match1 (
        .i_cfg(st_q.cfg1),
        .i_req(i_req),
        .i_sup(i_sup),
        .i_snp(i_snp),
        .o_hit(hit1),
        .o_cfg_valid(valid1)
    );

    function automatic logic [31:0] hi_word(input logic [37:0] c);
        hi_word = {26'h0, c[37:32]};
    endfunction

    function automatic logic [31:0] cnt_word(input logic [CNT_W-1:0] c);
        logic [31:0] w;
        w = 32'h0;
        w[CNT_W-1:0] = c;
        cnt_word = w;
    endfunction

    // =========================================
    // next state
    always_comb begin
        st_d = st_q;
        st_d.rdata = 32'h0;
        // one increment per completed matching transaction
        if (i_done && hit0) begin
            st_d.cnt0 = st_q.cnt0 + 1'b1;
        end
        if (i_done && hit1) begin
            st_d.cnt1 = st_q.cnt1 + 1'b1;
        end
        if (i_wr) begin
            case (i_addr)
                ocrf_pkg::ADDR_CFG0_LO: st_d.cfg0[31:0] = i_wdata;
                ocrf_pkg::ADDR_CFG0_HI: st_d.cfg0[37:32] = i_wdata[5:0];
                ocrf_pkg::ADDR_CFG1_LO: st_d.cfg1[31:0] = i_wdata;
                ocrf_pkg::ADDR_CFG1_HI: st_d.cfg1[37:32] = i_wdata[5:0];
                // a software write to a counter wins over a same-cycle increment
                ocrf_pkg::ADDR_CNT0: st_d.cnt0 = i_wdata[CNT_W-1:0];
                ocrf_pkg::ADDR_CNT1: st_d.cnt1 = i_wdata[CNT_W-1:0];
                default: begin
                end
            endcase
        end
        if (i_rd) begin
            case (i_addr)
                ocrf_pkg::ADDR_CFG0_LO: st_d.rdata = st_q.cfg0[31:0];
                ocrf_pkg::ADDR_CFG0_HI: st_d.rdata = hi_word(st_q.cfg0);
                ocrf_pkg::ADDR_CFG1_LO: st_d.rdata = st_q.cfg1[31:0];
                ocrf_pkg::ADDR_CFG1_HI: st_d.rdata = hi_word(st_q.cfg1);
                ocrf_pkg::ADDR_CNT0: st_d.rdata = cnt_word(st_q.cnt0);
                ocrf_pkg::ADDR_CNT1: st_d.rdata = cnt_word(st_q.cnt1);
                ocrf_pkg::ADDR_STATUS: st_d.rdata = {30'h0, valid1, valid0};
                default: st_d.rdata = 32'h0;
            endcase
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            st_q.cfg0 <= ocrf_pkg::CFG_RESET;
            st_q.cfg1 <= ocrf_pkg::CFG_RESET;
            st_q.cnt0 <= '0;
            st_q.cnt1 <= '0;
            st_q.rdata <= 32'h0;
        end else begin
            st_q <= st_d;
        end
    end

    assign o_rdata = st_q.rdata;
    assign o_count0 = st_q.cnt0;
    assign o_count1 = st_q.cnt1;

    // =========================================
    // checks
    no_req_nocount_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        (st_q.cfg0[15:0] == 16'h0 && !i_wr) |=> st_q.cnt0 == $past(st_q.cnt0))
        else $error("counter 0 moved with no request bit");
    count_step_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        (i_done && hit0 && !i_wr) |=> st_q.cnt0 == $past(st_q.cnt0) + 1'b1)
        else $error("counter 0 missed a matching transaction");
    any_accepts_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        (st_q.cfg0[16] && st_q.cfg0[i_req] && ocrf_pkg::REQ_VALID_MASK[i_req]) |-> hit0)
        else $error("catch-all did not accept response");
    resp_valid_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        (!st_q.cfg0[16] && st_q.cfg0[37:31] == 7'h0) |-> !valid0)
        else $error("response pattern valid without snoop bit");
    demand_data_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        (st_q.cfg0[16:0] == 17'h10001) |-> (hit0 == (i_req == 4'h0)))
        else $error("bit 0 selection wrong");
    other_req_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        (st_q.cfg1[16:0] == 17'h18000) |-> (hit1 == (i_req == 4'hF)))
        else $error("bit 15 selection wrong");
    sep_regs_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        (i_wr && i_addr == ocrf_pkg::ADDR_CFG0_LO) |=> st_q.cfg1 == $past(st_q.cfg1))
        else $error("config 0 write disturbed config 1");
    local_dram_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        (st_q.cfg0[16:0] == 17'h00001 && st_q.cfg0[30:17] == 14'h0020
         && st_q.cfg0[37:31] == 7'h01 && i_req == 4'h0 && i_snp == 3'h0)
        |-> (hit0 == (i_sup == 4'h5)))
        else $error("local dram supplier selection wrong");
    read_lat_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        (i_rd && i_addr == ocrf_pkg::ADDR_STATUS) |=> o_rdata[0] == $past(valid0))
        else $error("status read wrong");
endmodule

/* File: pkg/ocrf_pkg.sv */
package ocrf_pkg;
    // =========================================
    // register map
    localparam logic [3:0] ADDR_CFG0_LO = 4'h0;
    localparam logic [3:0] ADDR_CFG0_HI = 4'h1;
    localparam logic [3:0] ADDR_CFG1_LO = 4'h2;
    localparam logic [3:0] ADDR_CFG1_HI = 4'h3;
    localparam logic [3:0] ADDR_CNT0 = 4'h4;
    localparam logic [3:0] ADDR_CNT1 = 4'h5;
    localparam logic [3:0] ADDR_STATUS = 4'h6;
    localparam int CFG_W = 38;
    localparam int HI_W = 6;
    localparam logic [37:0] CFG_RESET = 38'h0;
    // =========================================
    // field layout of the filter configuration
    localparam int REQ_LSB = 0;
    localparam int REQ_MSB = 15;
    localparam int ANY_BIT = 16;
    localparam int SUP_LSB = 17;
    localparam int SUP_MSB = 30;
    localparam int SNP_LSB = 31;
    localparam int SNP_MSB = 37;
    // implemented request bits: 0..11 and 15
    localparam logic [15:0] REQ_VALID_MASK = 16'h8FFF;
    // implemented supplier bits 17..22 (relative to bit 17)
    localparam logic [13:0] SUP_VALID_MASK = 14'h003F;
    // =========================================
    // request class codes reported by the transaction path
    typedef enum logic [3:0] {
        OCRF_REQ_DMND_DATA = 4'h0,
        OCRF_REQ_DMND_OWN = 4'h1,
        OCRF_REQ_DMND_CODE = 4'h2,
        OCRF_REQ_WRITEBACK = 4'h3,
        OCRF_REQ_L2PF_DATA = 4'h4,
        OCRF_REQ_L2PF_OWN = 4'h5,
        OCRF_REQ_L2PF_CODE = 4'h6,
        OCRF_REQ_L3PF_LOAD = 4'h7,
        OCRF_REQ_L3PF_OWN = 4'h8,
        OCRF_REQ_L3PF_CODE = 4'h9,
        OCRF_REQ_LOCKED = 4'hA,
        OCRF_REQ_STREAM = 4'hB,
        OCRF_REQ_OTHER = 4'hF
    } ocrf_req_t;
    // supplier codes: index into the supplier field
    typedef enum logic [3:0] {
        OCRF_SUP_UNKNOWN = 4'h0,
        OCRF_SUP_L3_M = 4'h1,
        OCRF_SUP_L3_E = 4'h2,
        OCRF_SUP_L3_S = 4'h3,
        OCRF_SUP_L3_F = 4'h4,
        OCRF_SUP_LOCAL_DRAM = 4'h5
    } ocrf_sup_t;
    // snoop codes: index into the snoop field
    typedef enum logic [2:0] {
        OCRF_SNP_NO_DETAIL = 3'h0,
        OCRF_SNP_UNNEEDED = 3'h1,
        OCRF_SNP_MISSED = 3'h2,
        OCRF_SNP_HIT_NOFWD = 3'h3,
        OCRF_SNP_REMOTE_FWD = 3'h4,
        OCRF_SNP_MODIFIED = 3'h5,
        OCRF_SNP_NON_DRAM = 3'h6
    } ocrf_snp_t;
endpackage

/* File: hdl/ocrf_match.sv */
`timescale 1ns/1ps
// =========================================
// one filter: combinational match of a completed transaction
module ocrf_match (
    input wire logic [37:0] i_cfg,
    input wire logic [3:0] i_req,
    input wire logic [3:0] i_sup,
    input wire logic [2:0] i_snp,
    output logic o_hit,
    output logic o_cfg_valid
);
    logic [15:0] req_f;
    logic [13:0] sup_f;
    logic [6:0] snp_f;
    logic req_ok;
    logic rsp_ok;
    always_comb begin
        req_f = i_cfg[ocrf_pkg::REQ_MSB:ocrf_pkg::REQ_LSB] & ocrf_pkg::REQ_VALID_MASK;
        sup_f = i_cfg[ocrf_pkg::SUP_MSB:ocrf_pkg::SUP_LSB] & ocrf_pkg::SUP_VALID_MASK;
        snp_f = i_cfg[ocrf_pkg::SNP_MSB:ocrf_pkg::SNP_LSB];
        // one-hot select of the class; multiple set bits OR together
        req_ok = req_f[i_req];
        // catch-all overrides supplier and snoop selection
        if (i_cfg[ocrf_pkg::ANY_BIT]) begin
            rsp_ok = 1'b1;
        end else begin
            // codes past the field read as not selected
            rsp_ok = (i_sup < 4'hE ? sup_f[i_sup] : 1'b0)
                & (i_snp < 3'h7 ? snp_f[i_snp] : 1'b0);
        end
        // an invalid pattern can never hit, so the count holds its value
        o_cfg_valid = (|req_f) & (i_cfg[ocrf_pkg::ANY_BIT] | ((|sup_f) & (|snp_f)));
        o_hit = req_ok & rsp_ok & o_cfg_valid;
    end
endmodule

/* File: testbench/ocrf_txn_model.sv */
`timescale 1ns/1ps
// =========================================
// completed-transaction source standing in for the cache path
module ocrf_txn_model (
    input wire logic i_clock,
    input wire logic i_sys_rst,
    input wire logic i_run,
    input wire logic i_slow,
    output logic o_done,
    output logic [3:0] o_req,
    output logic [3:0] o_sup,
    output logic [2:0] o_snp
);
    logic [3:0] pick;
    initial begin
        o_done = 1'b0;
        o_req = 4'h0;
        o_sup = 4'h0;
        o_snp = 3'h0;
    end
    always @(posedge i_clock) begin
        if (!i_sys_rst && i_run && (!i_slow || $urandom_range(3) == 0)) begin
            pick = 4'($urandom_range(12));
            o_done <= 1'b1;
            o_req <= (pick == 4'hC) ? 4'hF : pick;
            o_sup <= 4'($urandom_range(5));
            o_snp <= 3'($urandom_range(6));
        end else begin
            // stale fields are scrambled so the filter cannot lean on them
            o_done <= 1'b0;
            o_req <= ~o_req;
            o_sup <= ~o_sup;
            o_snp <= ~o_snp;
        end
    end
endmodule

/* File: testbench/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
    logic i_clock = 1'b0;
    logic i_sys_rst = 1'b1;
    logic [3:0] i_addr = 4'h0;
    logic [31:0] i_wdata = 32'h0;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic run = 1'b0;
    logic slow = 1'b0;
    logic i_done;
    logic [3:0] i_req;
    logic [3:0] i_sup;
    logic [2:0] i_snp;
    logic [31:0] o_rdata;
    logic [31:0] o_count0;
    logic [31:0] o_count1;
    logic [37:0] cfg [2];
    logic [31:0] cnt [2];
    logic [31:0] exp_rdata;
    int fail_count = 0;
    int n_tests = 0;
    always #20 i_clock = ~i_clock;
    ocrf_filter #(.CNT_W(32)) DUT (.i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_done(i_done),
        .i_req(i_req), .i_sup(i_sup), .i_snp(i_snp), .o_count0(o_count0), .o_count1(o_count1));
    ocrf_txn_model partner (.i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_run(run),
        .i_slow(slow), .o_done(i_done), .o_req(i_req), .o_sup(i_sup), .o_snp(i_snp));
    // =========================================
    // reference model
    function automatic logic hit(logic [37:0] c, logic [3:0] r, logic [3:0] s, logic [2:0] n);
        logic req_ok;
        logic rsp_ok;
        req_ok = c[r] && !(r inside {4'hC, 4'hD, 4'hE});
        rsp_ok = c[16] || (s <= 4'h5 && n <= 3'h6 && c[17 + s] && c[31 + n]);
        return req_ok && rsp_ok;
    endfunction
    function automatic logic cfg_ok(logic [37:0] c);
        return |(c[15:0] & 16'h8FFF) && (c[16] || (|c[22:17] && |c[37:31]));
    endfunction
    function automatic logic [31:0] reg_val(logic [3:0] a);
        case (a)
            4'h0, 4'h2: return cfg[a[1]][31:0];
            4'h1, 4'h3: return {26'h0, cfg[a[1]][37:32]};
            4'h4, 4'h5: return cnt[a[0]];
            4'h6: return {30'h0, cfg_ok(cfg[1]), cfg_ok(cfg[0])};
            default: return 32'h0;
        endcase
    endfunction
    always @(posedge i_clock) begin
        if (i_sys_rst) begin
            cfg = '{38'h0, 38'h0};
            cnt = '{32'h0, 32'h0};
            exp_rdata = 32'h0;
        end else begin
            exp_rdata = i_rd ? reg_val(i_addr) : 32'h0;
            for (int k = 0; k < 2; k++) begin
                if (i_done && hit(cfg[k], i_req, i_sup, i_snp)) cnt[k] = cnt[k] + 32'h1;
            end
            // a counter write lands after the increment, so the write wins
            if (i_wr && i_addr[3:2] == 2'b00 && !i_addr[0]) cfg[i_addr[1]][31:0] = i_wdata;
            if (i_wr && i_addr[3:2] == 2'b00 && i_addr[0]) cfg[i_addr[1]][37:32] = i_wdata[5:0];
            if (i_wr && i_addr[3:1] == 3'b010) cnt[i_addr[0]] = i_wdata;
        end
    end
    // =========================================
    // comparison and closing
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    always @(negedge i_clock) begin
        if (!i_sys_rst) begin
            check("rdata", exp_rdata, o_rdata);
            check("count0", cnt[0], o_count0);
            check("count1", cnt[1], o_count1);
        end
    end
    task automatic test_done();
        if (fail_count == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (60000) @(posedge i_clock);
        fail_count++;
        test_done();
    end
    // =========================================
    // stimulus: every call starts just after a rising edge
    task automatic bus(input logic wr, input logic rd, input logic [3:0] a, input logic [31:0] d);
        i_wr <= wr;
        i_rd <= rd;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clock);
    endtask
    task automatic read_all();
        for (int a = 0; a < 16; a++) bus(1'b0, 1'b1, 4'(a), 32'h0);
    endtask
    initial begin
        logic [37:0] c;
        void'($urandom(56651));
        repeat (2) @(posedge i_clock);
        i_sys_rst <= 1'b0;
        read_all();
        run <= 1'b1;
        for (int t = 0; t < 400; t++) begin
            case ($urandom_range(3))
                0: c = 38'({$urandom, $urandom});
                1: c = (38'h1 << $urandom_range(15)) | (38'h1 << ($urandom_range(5) + 17))
                    | (38'h1 << ($urandom_range(6) + 31));
                2: c = (38'h1 << $urandom_range(15)) | 38'h10000;
                default: c = 38'({$urandom, $urandom}) & ~38'hFFFF;
            endcase
            slow <= t[0];
            // upper bits of the high word are junk on purpose: only six are kept
            bus(1'b1, 1'b0, {2'b00, t[1], 1'b0}, c[31:0]);
            bus(1'b1, 1'b0, {2'b00, t[1], 1'b1}, {26'($urandom), c[37:32]});
            repeat (12) begin
                if ($urandom_range(7) == 0) bus(1'b1, 1'b0, 4'h4 | 4'(t[2]), $urandom);
                else bus(1'b0, 1'b1, 4'($urandom_range(15)), 32'h0);
            end
        end
        // reset in mid-traffic must clear configs and counters again
        i_sys_rst <= 1'b1;
        repeat (2) bus(1'b0, 1'b0, 4'h0, 32'h0);
        i_sys_rst <= 1'b0;
        read_all();
        // idle edges so the last read and any late count are still compared
        repeat (2) bus(1'b0, 1'b0, 4'h0, 32'h0);
        test_done();
    end
endmodule
